// *** hw/rsts_sram.sv ***
/*
 * Registered self-timed SRAM core: input capture, internal write strobe,
 * self-timed output register, hidden writes, deselect and clock enable.
 * Assumes the outside decode selects at most one device per output group.
 */
`timescale 1ns/100ps
`default_nettype none

// Contract
// [R1] Capture address, data, write, select each edge
// [R2] Output register loads fixed delay after edge
// [R3] Write strobe generated internally from captured controls
// [R4] Write leaves output register and drivers unchanged
// [R5] Outputs hold last read word until changed
// [R6] Clock enable asserted means no operation
// [R7] Gating done on chip without clock slivers
// [R8] Unselected non-write cycle disables outputs
// [R9] Bus write keeps deselected outputs enabled
// [R10] Outside decode selects one device at most
// [R11] Unused parity and scan leave behaviour intact
// [R12] Selected read returns word after access delay; a read followed by another read at the next edge is dropped
// [R13] Address and data widths are parameters
module rsts_sram
	import rsts_pkg::*;
#(
	parameter int ADDR_W = RSTS_ADDR_W, // [R13]
	parameter int DATA_W = RSTS_DATA_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              clk_hold,
	input  wire logic              sel,
	input  wire logic              wr,
	input  wire logic              bus_wr,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              par_en,
	input  wire logic              scan_en,
	input  wire logic              scan_in,
	output logic      [DATA_W-1:0] dout,
	output logic                   dout_oe,
	output logic                   par_err,
	output logic                   scan_out
);

	localparam int DLY_W = $clog2(RSTS_ACCESS_CYC + 1);

	// Captured cycle and timing state
	logic              cap_vld_r, cap_vld_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] wdata_r, wdata_nxt;
	rsts_op_t          op_r, op_nxt;
	logic [DLY_W-1:0]  dly_r, dly_nxt;
	logic [ADDR_W-1:0] raddr_r, raddr_nxt;
	logic [DATA_W-1:0] dout_r, dout_nxt;
	logic              oe_r, oe_nxt;
	logic              ld_r, ld_nxt;
	logic              par_r, par_nxt;
	logic              scan_r, scan_nxt;
	logic              we;
	logic              re;
	logic [DATA_W-1:0] rdata;
	rsts_cyc_t         cyc;
	logic              rd_go;
	logic              ds_go;

	assign cyc = '{sel: sel, wr: wr, bus_wr: bus_wr, addr: addr, wdata: wdata};

	// Cycle kinds taken at this edge; stalled edges take none
	assign rd_go = !clk_hold && (rsts_decode(cyc) == RSTS_OP_READ);
	assign ds_go = !clk_hold && (rsts_decode(cyc) == RSTS_OP_DESEL);

	// Write strobe lasts one cycle after capture, fully internal
	assign we = cap_vld_r && (op_r == RSTS_OP_WRITE); // [R3]
	// Array read launched when the timer reaches its last step
	assign re = (dly_r == DLY_W'(1));

	rsts_array #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W)
	) rsts_array_i (
		.clk   (clk),
		.we    (we),
		.waddr (addr_r),
		.wdata (wdata_r),
		.re    (re),
		.raddr (raddr_r),
		.rdata (rdata)
	);

	// Next-state logic for capture, timer and outputs
	always_comb begin
		cap_vld_nxt = 1'b0;
		addr_nxt    = addr_r;
		wdata_nxt   = wdata_r;
		op_nxt      = op_r;
		dly_nxt     = dly_r;
		raddr_nxt   = raddr_r;
		dout_nxt    = dout_r;
		oe_nxt      = oe_r;
		ld_nxt      = 1'b0;
		par_nxt     = par_r;
		scan_nxt    = scan_en ? scan_in : scan_r; // [R11]
		// Stalled edge: gating is a synchronous enable, no gated clock
		if (!clk_hold) begin // [R6] [R7]
			cap_vld_nxt = 1'b1; // [R1]
			addr_nxt    = cyc.addr;
			wdata_nxt   = cyc.wdata;
			op_nxt      = rsts_decode(cyc);
			unique case (rsts_decode(cyc))
				RSTS_OP_READ: begin
					raddr_nxt = cyc.addr; // [R12]
					dly_nxt   = DLY_W'(RSTS_ACCESS_CYC); // [R2]
				end
				RSTS_OP_DESEL: begin
					oe_nxt  = 1'b0; // [R8]
					dly_nxt = '0;
				end
				RSTS_OP_WRITE,
				RSTS_OP_IDLE: begin
					// Outputs untouched, pending read still completes
					oe_nxt = oe_r; // [R4] [R9]
				end
			endcase
		end
		// Self-timed countdown; writes, bus writes and stalls let it run on,
		// a new read restarts it and a deselect cancels it
		if (dly_r != '0 && !rd_go && !ds_go)
			dly_nxt = dly_r - DLY_W'(1);
		// A deselect drops a load in flight, so drivers never come back on
		if (ld_r && !ds_go) begin
			dout_nxt = rdata; // [R2] [R12]
			oe_nxt   = 1'b1;
			par_nxt  = par_en & ^rdata; // [R11]
		end else if (!par_en) begin
			par_nxt = 1'b0;
		end
		ld_nxt = re && !ds_go; // [R8]
		// Otherwise the last read word is simply held
		if (!ld_r)
			dout_nxt = dout_r; // [R5]
	end

	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cap_vld_r <= 1'b0;
			addr_r    <= '0;
			wdata_r   <= '0;
			op_r      <= RSTS_OP_IDLE;
			dly_r     <= '0;
			raddr_r   <= '0;
			dout_r    <= '0;
			oe_r      <= 1'b0;
			ld_r      <= 1'b0;
			par_r     <= 1'b0;
			scan_r    <= 1'b0;
		end else begin
			cap_vld_r <= cap_vld_nxt;
			addr_r    <= addr_nxt;
			wdata_r   <= wdata_nxt;
			op_r      <= op_nxt;
			dly_r     <= dly_nxt;
			raddr_r   <= raddr_nxt;
			dout_r    <= dout_nxt;
			oe_r      <= oe_nxt;
			ld_r      <= ld_nxt;
			par_r     <= par_nxt;
			scan_r    <= scan_nxt;
		end
	end

	assign dout     = dout_r;
	assign dout_oe  = oe_r;
	assign par_err  = par_r;
	assign scan_out = scan_r;

	// Checks
	AST_CAPTURE: assert property (@(posedge clk) disable iff (rst) // [R1]
		!clk_hold |=> cap_vld_r && addr_r == $past(addr))
		else $error("inputs not captured");
	AST_HOLD_NOP: assert property (@(posedge clk) disable iff (rst) // [R6]
		clk_hold |=> !cap_vld_r && $stable(addr_r))
		else $error("stalled cycle did work");
	// Read delay check is written for the default two-cycle access delay
	AST_READ_DELAY: assert property (@(posedge clk) disable iff (rst) // [R2]
		rd_go ##1 (!rd_go && !ds_go) ##1 !ds_go ##1 !ds_go |-> ld_r ##1 dout_oe)
		else $error("read data not loaded after access delay");
	AST_WRITE_STROBE: assert property (@(posedge clk) disable iff (rst) // [R3]
		!clk_hold && sel && wr |=> we ##1 (!we || $past(!clk_hold && sel && wr)))
		else $error("write strobe wrong");
	AST_HIDDEN_WRITE: assert property (@(posedge clk) disable iff (rst) // [R4]
		!clk_hold && sel && wr && dly_r == '0 && !ld_r |=> $stable(dout) && $stable(dout_oe))
		else $error("write disturbed outputs");
	AST_DESELECT: assert property (@(posedge clk) disable iff (rst) // [R8]
		!clk_hold && !sel && !bus_wr |=> !dout_oe)
		else $error("deselect did not disable outputs");
	AST_BUS_WRITE: assert property (@(posedge clk) disable iff (rst) // [R9]
		!clk_hold && !sel && bus_wr && dout_oe |=> dout_oe)
		else $error("outputs dropped during bus write");
	AST_HOLD_DATA: assert property (@(posedge clk) disable iff (rst) // [R5]
		!ld_r |=> $stable(dout))
		else $error("output changed without a read");
	AST_PARITY_OFF: assert property (@(posedge clk) disable iff (rst) // [R11]
		!par_en |=> !par_err)
		else $error("parity flagged while unused");
	AST_STROBE_SRC: assert property (@(posedge clk) disable iff (rst) // [R3]
		we |-> $past(!clk_hold && sel && wr))
		else $error("write strobe without a captured write");
	AST_SCAN_OFF: assert property (@(posedge clk) disable iff (rst) // [R11]
		!scan_en |=> $stable(scan_out))
		else $error("scan bit moved while unused");
	COV_READ: cover property (@(posedge clk) disable iff (rst) ld_r);
	COV_WRITE: cover property (@(posedge clk) disable iff (rst) we);
	COV_HIDDEN: cover property (@(posedge clk) disable iff (rst) ld_r && we);
	COV_DESEL: cover property (@(posedge clk) disable iff (rst) $fell(dout_oe));
	COV_DESEL_PEND: cover property (@(posedge clk) disable iff (rst) ds_go && dly_r != '0);

endmodule : rsts_sram

`default_nettype wire

// *** hw/rsts_pkg.sv ***
/*
 * Package for the registered self-timed static RAM: widths, access delay,
 * packed carrier for the captured cycle, operation codes and their decode.
 * Assumes one clock domain, clk, and an active-high asynchronous reset.
 */
package rsts_pkg;

	localparam int RSTS_ADDR_W     = 10;
	localparam int RSTS_DATA_W     = 32;
	// Internal access delay from the input edge to the array read; the output register loads one cycle later
	localparam int RSTS_ACCESS_NS  = 16;
	localparam int RSTS_CLK_NS     = 8;
	localparam int RSTS_ACCESS_CYC = (RSTS_ACCESS_NS + RSTS_CLK_NS - 1) / RSTS_CLK_NS;
	// Write strobe length generated on chip
	localparam int RSTS_WSTB_CYC   = 1;

	// One captured bus cycle
	typedef struct packed {
		logic                   sel;
		logic                   wr;
		logic                   bus_wr;
		logic [RSTS_ADDR_W-1:0] addr;
		logic [RSTS_DATA_W-1:0] wdata;
	} rsts_cyc_t;

	typedef enum logic [1:0] {
		RSTS_OP_IDLE,
		RSTS_OP_READ,
		RSTS_OP_WRITE,
		RSTS_OP_DESEL
	} rsts_op_t;

	// Decodes a captured cycle into its operation
	function automatic rsts_op_t rsts_decode(input rsts_cyc_t c);
		if (c.sel && c.wr)
			return RSTS_OP_WRITE;
		else if (c.sel)
			return RSTS_OP_READ;
		else if (c.bus_wr)
			return RSTS_OP_IDLE;
		else
			return RSTS_OP_DESEL;
	endfunction : rsts_decode

endpackage : rsts_pkg

// *** hw/rsts_array.sv ***
/*
 * Storage array of the self-timed RAM, one write port and one read port,
 * read data registered. Assumes the caller times the strobes.
 */
`timescale 1ns/100ps
`default_nettype none

module rsts_array
	import rsts_pkg::*;
#(
	parameter int ADDR_W = RSTS_ADDR_W,
	parameter int DATA_W = RSTS_DATA_W
) (
	input  wire logic              clk,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              re,
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0] rdata
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Write port and registered read port
	always_ff @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
		if (re)
			rdata <= mem[raddr];
	end

endmodule : rsts_array

`default_nettype wire

// *** dv/rsts_host.sv ***
/*
 * Processor-side bus model: issues one RAM cycle per call, stalls otherwise.
 * Assumes the testbench calls its tasks and that clk is the RAM clock.
 */
`timescale 1ns/100ps
`default_nettype none

module rsts_host
	import rsts_pkg::*;
#(
	parameter int AW = RSTS_ADDR_W,
	parameter int DW = RSTS_DATA_W
) (
	input  wire logic          clk,
	output var logic           sel,
	output var logic           wr,
	output var logic           bus_wr,
	output var logic           clk_hold,
	output var logic [AW-1:0]  addr,
	output var logic [DW-1:0]  wdata
);
	// Bus starts stalled
	initial begin
		{sel, wr, bus_wr, addr, wdata} = '0;
		clk_hold = 1'b1;
	end

	// One cycle driven after an edge; this device alone is selected
	task automatic issue(input logic s, w, b, h, input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		sel <= s;
		wr <= w;
		bus_wr <= b;
		clk_hold <= h;
		addr <= a;
		wdata <= d;
	endtask : issue

	// Stall cycle; released address and data lines show inverted values
	task automatic idle();
		issue(1'b0, 1'b0, 1'b0, 1'b1, ~addr, ~wdata);
	endtask : idle
endmodule : rsts_host

`default_nettype wire

// *** dv/rsts_sram_tb.sv ***
/*
 * Self-checking testbench of the self-timed SRAM with a host bus model.
 * Assumes the design answers reads three edges after capture.
 */
`timescale 1ns/100ps
`default_nettype none

module rsts_sram_tb
	import rsts_pkg::*;
;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   sel, wr, bus_wr, clk_hold, dout_oe, par_err, scan_out;
	logic [RSTS_ADDR_W-1:0] addr;
	logic [RSTS_DATA_W-1:0] wdata, dout, last = '0;
	logic                   oe_x = 1'b0;
	int                     err_total = 0;
	int                     num_checks = 0;

	// 125 MHz clock
	always #4 clk = ~clk;

	rsts_host rsts_host_i (.clk(clk), .sel(sel), .wr(wr), .bus_wr(bus_wr), .clk_hold(clk_hold),
		.addr(addr), .wdata(wdata));

	rsts_sram rsts_sram_i (.clk(clk), .rst(rst), .clk_hold(clk_hold), .sel(sel), .wr(wr), .bus_wr(bus_wr),
		.addr(addr), .wdata(wdata), .par_en(1'b0), .scan_en(1'b0), .scan_in(1'b0), .dout(dout),
		.dout_oe(dout_oe), .par_err(par_err), .scan_out(scan_out));

	// Word compare
	task automatic chk_w(input logic [RSTS_DATA_W-1:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_w

	// Flag compare
	task automatic chk_b(input logic got, exp);
		chk_w({31'h0, got}, {31'h0, exp});
	endtask : chk_b

	// Write cycle
	task automatic wrw(input logic [RSTS_ADDR_W-1:0] a, input logic [RSTS_DATA_W-1:0] d);
		rsts_host_i.issue(1'b1, 1'b1, 1'b0, 1'b0, a, d);
	endtask : wrw

	// Read cycle, old word until the load edge
	task automatic rd(input logic [RSTS_ADDR_W-1:0] a, input logic [RSTS_DATA_W-1:0] d);
		rsts_host_i.issue(1'b1, 1'b0, 1'b0, 1'b0, a, ~d);
		repeat (3) rsts_host_i.idle();
		#1;
		if (oe_x) chk_w(dout, last);
		rsts_host_i.idle();
		#1;
		chk_w(dout, d);
		chk_b(dout_oe, 1'b1);
		chk_b(par_err, 1'b0);
		chk_b(scan_out, 1'b0);
		last = d;
		oe_x = 1'b1;
	endtask : rd

	// Back-to-back writes, then two separate reads, top address too
	task automatic t_wr_rd();
		wrw(10'h005, 32'hA5A5_0F0F);
		wrw(10'h3FF, 32'h1234_5678);
		rd(10'h005, 32'hA5A5_0F0F);
		rd(10'h3FF, 32'h1234_5678);
	endtask : t_wr_rd

	// Writes hidden under a read still in flight, back to back
	task automatic t_hidden();
		rsts_host_i.issue(1'b1, 1'b0, 1'b0, 1'b0, 10'h005, 32'h0);
		wrw(10'h001, 32'h0F0F_A5A5);
		wrw(10'h005, 32'hC3C3_9696);
		rsts_host_i.idle();
		#1;
		chk_w(dout, last);
		chk_b(dout_oe, 1'b1);
		rsts_host_i.idle();
		#1;
		chk_w(dout, 32'hA5A5_0F0F);
		last = 32'hA5A5_0F0F;
		rd(10'h005, 32'hC3C3_9696);
	endtask : t_hidden

	// Stalled write and read do nothing
	task automatic t_hold();
		rsts_host_i.issue(1'b1, 1'b1, 1'b0, 1'b1, 10'h3FF, 32'hDEAD_BEEF);
		rsts_host_i.issue(1'b1, 1'b0, 1'b0, 1'b1, 10'h001, 32'h0);
		repeat (4) rsts_host_i.idle();
		#1;
		chk_w(dout, last);
		rd(10'h3FF, 32'h1234_5678);
	endtask : t_hold

	// Bus write keeps drivers on, plain deselect turns them off
	task automatic t_desel();
		rsts_host_i.issue(1'b0, 1'b0, 1'b1, 1'b0, 10'h001, 32'h0);
		repeat (2) rsts_host_i.idle();
		#1;
		chk_b(dout_oe, 1'b1);
		rsts_host_i.issue(1'b0, 1'b0, 1'b0, 1'b0, 10'h001, 32'h0);
		repeat (2) rsts_host_i.idle();
		#1;
		chk_b(dout_oe, 1'b0);
		chk_w(dout, last);
		// Deselect right behind a read cancels its load
		rsts_host_i.issue(1'b1, 1'b0, 1'b0, 1'b0, 10'h001, 32'h0);
		rsts_host_i.issue(1'b0, 1'b0, 1'b0, 1'b0, 10'h001, 32'h0);
		repeat (3) rsts_host_i.idle();
		#1;
		chk_b(dout_oe, 1'b0);
		chk_w(dout, last);
		oe_x = 1'b0;
		rd(10'h005, 32'hC3C3_9696);
	endtask : t_desel

	// Counts and verdict
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_wr_rd();
		t_hidden();
		t_hold();
		t_desel();
		finish_test();
	end

	// Watchdog
	initial begin
		repeat (2000) @(posedge clk);
		err_total++;
		finish_test();
	end
endmodule : rsts_sram_tb

`default_nettype wire
